// ### iep_periph_model.sv
module iep_periph_model
    import iep_pkg::*;
(
    input wire logic mclk,
    input wire logic eppOn,
    input wire iep_pin_out_t pinOut,
    output iep_pin_in_t pinIn
);
    timeunit 1ns;
    timeprecision 1ns;
    int lag = 6;
    int lost = 0;
    int wt = 0;
    logic [7:0] lastWr;
    logic [3:0] lastWay;
    initial pinIn = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 8'hFF};
    always @(posedge mclk) pinIn.pe <= pinOut.initN;
    // one reverse byte: present, ack low, then hold data until autofd falls again
    task automatic send(input logic [7:0] b, input logic cmd);
        int n;
        @(posedge mclk);
        pinIn.data <= b;
        pinIn.busy <= ~cmd;
        pinIn.ackN <= 1'b0;
        n = 0;
        while (!pinOut.autofdN && n < 600) begin
            @(posedge mclk);
            n++;
        end
        pinIn.ackN <= 1'b1;
        while (pinOut.autofdN && n < 600) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 600) lost++;
        pinIn.data <= ~b;
    endtask : send
    // epp handshake: busy rises lag+1 cycles after a strobe, falls once both released
    always @(posedge mclk) begin
        if (eppOn && (!pinOut.autofdN || !pinOut.hostSelN) && !pinIn.busy) begin
            if (wt < lag) wt <= wt + 1;
            else begin
                wt <= 0;
                lastWay <= {pinOut.strobeN, pinOut.dataOe, pinOut.hostSelN, pinOut.autofdN};
                lastWr <= pinOut.data;
                if (pinOut.strobeN) pinIn.data <= 8'h5A;
                pinIn.busy <= 1'b1;
            end
        end else if (eppOn && pinOut.autofdN && pinOut.hostSelN && pinIn.busy) begin
            pinIn.busy <= 1'b0;
            pinIn.data <= 8'hA5;
        end
    end
endmodule : iep_periph_model

// ### iep_pkg.sv
package iep_pkg;
    // register byte offsets
    localparam logic [11:0] PORT_CTRL_OFS = 12'h010;
    localparam logic [11:0] CHAN_DATA_OFS = 12'h020;
    // port control: software-written bits
    localparam int CB_REV = 0;
    localparam int CB_EPP = 1;
    localparam int CB_INIT = 2;
    localparam int CB_HSEL = 3;
    localparam int CB_DMA_REQUEST_ENABLE = 4;
    localparam int CB_IRQE = 5;
    localparam int CB_AFD = 6;
    localparam int CB_STRB = 8;
    localparam int STRB_W = 5;
    localparam logic [15:0] CTRL_RST = 16'h014C;
    // port control: read-only state bits
    localparam int SB_IBR = 16;
    localparam int SB_CNT = 17;
    localparam int SB_CMD = 20;
    localparam int SB_TO = 21;
    localparam int SB_PE = 24;
    localparam int SB_PSEL = 25;
    localparam int SB_FAULT = 26;
    localparam int SB_BUSY = 27;
    localparam int SB_ACK = 28;
    localparam int SB_EPPB = 29;
    // strobe width step and character timer
    localparam int CLK_NS = 40;
    localparam int STEP_NS = 500;
    localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int TO_MULT = 10;
    localparam int TMR_W = 12;
    localparam int RX_BYTES = 4;

    typedef struct packed {
        logic ackN;
        logic busy;
        logic pe;
        logic pSel;
        logic faultN;
        logic [7:0] data;
    } iep_pin_in_t;

    typedef struct packed {
        logic strobeN;
        logic autofdN;
        logic hostSelN;
        logic initN;
        logic dataOe;
        logic [7:0] data;
    } iep_pin_out_t;

    typedef enum logic [3:0] {
        EPP_IDLE = 4'b0001,
        EPP_WNB = 4'b0010,
        EPP_WB = 4'b0100,
        EPP_FIN = 4'b1000
    } iep_epp_st_t;
endpackage : iep_pkg

// ### iep_port_host.sv
// Operation
// - Software lowers INIT and sets reverse select; hardware then handles inbound bytes.
// - Software raises INIT, waits for PE high, then clears reverse select.
// - STROBE stays high throughout reverse mode.
// - INIT output follows its control bit statically; host select follows its bit outside EPP mode.
// - PE, peripheral select and FAULT levels are readable in port control.
// - AUTOFD goes high after ACK falls, low again after ACK rises.
// - Bytes pack into data register; ready flag at four bytes or close.
// - Ready flag drives interrupt and DMA request, each when its enable bit is set.
// - BUSY low marks command byte: stored, buffer closed, command flag set.
// - Command flag clears on a data register read.
// - Character timer at ten strobe widths sets ready and timeout flags.
// - Timer idle until a byte is held; restarts on every byte.
// - Close flags go out as descriptor status bits 15 and 14.
// - EPP cycles stall the bus with wait states until handshake ends.
// - EPP accepts only single byte at its lane; otherwise an error.
// - EPP data write: data, STROBE low, AUTOFD after BUSY low, wait.
// - EPP data read: STROBE high, AUTOFD handshake, latch on release.
// - EPP address write uses host select instead of AUTOFD.
// - EPP address read uses host select, latching data on release.
//
// Chosen here: the address map and register access over APB.
module iep_port_host
    import iep_pkg::*;
#(
    parameter int LANE_DATA = 0,
    parameter int LANE_ADDR = 1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire iep_pin_in_t pinIn,
    output iep_pin_out_t pinOut,
    output logic inboundIrq,
    output logic dmaReq,
    output logic [1:0] dmaCloseStat
);
    if (LANE_DATA == LANE_ADDR || LANE_DATA > 3 || LANE_ADDR > 3 || LANE_DATA < 0 || LANE_ADDR < 0)
        $error("lane parameters must be distinct and 0..3");

    localparam logic [1:0] LD = 2'(LANE_DATA);
    localparam logic [1:0] LA = 2'(LANE_ADDR);

    logic [12:0] sync1_r;
    logic [12:0] sync2_r;
    iep_pin_in_t pinS;
    logic [15:0] ctrl_r;
    logic [31:0] buf_r;
    logic [2:0] cnt_r;
    logic ibr_r;
    logic cmd_r;
    logic to_r;
    logic revAfdN_r;
    logic [TMR_W-1:0] tmr_r;
    logic [TMR_W-1:0] tmrLimit;
    logic [STRB_W-1:0] units;
    iep_epp_st_t st_r;
    logic eppAddr_r;
    logic eppWr_r;
    logic [7:0] eppRd_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    iep_pin_out_t pin_r;
    logic irq_r;
    logic dmaReq_r;
    logic [1:0] close_r;

    logic acc;
    logic hitCtrl;
    logic hitData;
    logic eppMode;
    logic revOn;
    logic eppHit;
    logic laneOk;
    logic isAddrLane;
    logic [1:0] lane;
    logic dataRead;
    logic accept;
    logic [31:0] ctrlRd;

    // two-flop synchroniser on every pin input
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync1_r <= 13'h1FFF;
            sync2_r <= 13'h1FFF;
        end else if (ce) begin
            sync1_r <= pinIn;
            sync2_r <= sync1_r;
        end
    end
    assign pinS = sync2_r;

    assign acc = psel & penable & ~pready_r;
    assign hitCtrl = paddr[11:2] == PORT_CTRL_OFS[11:2];
    assign hitData = paddr[11:2] == CHAN_DATA_OFS[11:2];
    assign eppMode = ctrl_r[CB_EPP];
    assign revOn = ctrl_r[CB_REV] & ~eppMode;
    assign eppHit = acc & hitData & eppMode;
    // writes select the lane by strobes, reads by address
    always_comb begin
        lane = paddr[1:0];
        laneOk = 1'b0;
        if (pwrite) begin
            laneOk = pstrb == (4'h1 << LD) || pstrb == (4'h1 << LA);
            lane = (pstrb == (4'h1 << LA)) ? LA : LD;
        end else begin
            laneOk = paddr[1:0] == LD || paddr[1:0] == LA;
        end
    end
    assign isAddrLane = lane == LA;
    assign dataRead = acc & hitData & ~eppMode & ~pwrite;
    assign accept = revOn & ~pinS.ackN & ~revAfdN_r & ~ibr_r & ~dataRead;
    assign units = (ctrl_r[CB_STRB +: STRB_W] == '0) ? STRB_W'(1) : ctrl_r[CB_STRB +: STRB_W];
    assign tmrLimit = TMR_W'(TO_MULT * STEP_CYC) * TMR_W'(units);

    always_comb begin
        ctrlRd = 32'h0;
        ctrlRd[15:0] = ctrl_r;
        ctrlRd[SB_IBR] = ibr_r;
        ctrlRd[SB_CNT +: 3] = cnt_r;
        ctrlRd[SB_CMD] = cmd_r;
        ctrlRd[SB_TO] = to_r;
        ctrlRd[SB_PE] = pinS.pe;
        ctrlRd[SB_PSEL] = pinS.pSel;
        ctrlRd[SB_FAULT] = pinS.faultN;
        ctrlRd[SB_BUSY] = pinS.busy;
        ctrlRd[SB_ACK] = pinS.ackN;
        ctrlRd[SB_EPPB] = st_r != EPP_IDLE;
    end

    // APB slave
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_r <= CTRL_RST;
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (ce) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            if (acc) begin
                if (eppHit && laneOk) begin
                    if (st_r == EPP_FIN) begin
                        pready_r <= 1'b1;
                        prdata_r <= 32'h0;
                        prdata_r[8*lane +: 8] <= eppWr_r ? 8'h00 : eppRd_r;
                    end
                end else if (eppHit) begin
                    pready_r <= 1'b1;
                    pslverr_r <= 1'b1;
                    prdata_r <= 32'h0;
                end else if (hitCtrl) begin
                    pready_r <= 1'b1;
                    prdata_r <= ctrlRd;
                    if (pwrite) begin
                        if (pstrb[0]) ctrl_r[7:0] <= pwdata[7:0];
                        if (pstrb[1]) ctrl_r[15:8] <= pwdata[15:8];
                    end
                end else if (hitData) begin
                    pready_r <= 1'b1;
                    prdata_r <= pwrite ? 32'h0 : buf_r;
                end else begin
                    pready_r <= 1'b1;
                    pslverr_r <= 1'b1;
                    prdata_r <= 32'h0;
                end
            end
        end
    end

    // reverse channel receive, packing and character timer
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            buf_r <= 32'h0;
            cnt_r <= 3'h0;
            ibr_r <= 1'b0;
            cmd_r <= 1'b0;
            to_r <= 1'b0;
            revAfdN_r <= 1'b0;
            tmr_r <= '0;
        end else if (ce) begin
            if (dataRead) begin
                cnt_r <= 3'h0;
                ibr_r <= 1'b0;
                cmd_r <= 1'b0;
                to_r <= 1'b0;
                tmr_r <= '0;
            end else if (accept) begin
                buf_r[8*cnt_r[1:0] +: 8] <= pinS.data;
                cnt_r <= cnt_r + 3'h1;
                revAfdN_r <= 1'b1;
                tmr_r <= '0;
                if (cnt_r == 3'(RX_BYTES - 1)) ibr_r <= 1'b1;
                if (!pinS.busy) begin
                    cmd_r <= 1'b1;
                    ibr_r <= 1'b1;
                end
            end else if (revOn && cnt_r != 3'h0 && !ibr_r) begin
                tmr_r <= tmr_r + 1'b1;
                if (tmr_r + 1'b1 >= tmrLimit) begin
                    ibr_r <= 1'b1;
                    to_r <= 1'b1;
                end
            end
            if (!revOn) begin
                revAfdN_r <= 1'b0;
            end else if (revAfdN_r && pinS.ackN) begin
                revAfdN_r <= 1'b0;
            end
        end
    end

    // pins and EPP handshake engine
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r <= EPP_IDLE;
            eppAddr_r <= 1'b0;
            eppWr_r <= 1'b0;
            eppRd_r <= 8'h00;
            pin_r <= '{strobeN: 1'b1, autofdN: 1'b1, hostSelN: 1'b1,
                       initN: 1'b1, dataOe: 1'b0, data: 8'h00};
        end else if (ce) begin
            pin_r.initN <= ctrl_r[CB_INIT];
            if (!eppMode) begin
                st_r <= EPP_IDLE;
                pin_r.strobeN <= 1'b1;
                pin_r.hostSelN <= ctrl_r[CB_HSEL];
                pin_r.autofdN <= revOn ? revAfdN_r : ctrl_r[CB_AFD];
                pin_r.dataOe <= 1'b0;
            end else begin
                case (st_r)
                    EPP_IDLE: begin
                        pin_r.strobeN <= 1'b1;
                        pin_r.autofdN <= 1'b1;
                        pin_r.hostSelN <= 1'b1;
                        pin_r.dataOe <= 1'b0;
                        if (eppHit && laneOk) begin
                            eppAddr_r <= isAddrLane;
                            eppWr_r <= pwrite;
                            pin_r.data <= pwdata[8*lane +: 8];
                            pin_r.dataOe <= pwrite;
                            pin_r.strobeN <= ~pwrite;
                            st_r <= EPP_WNB;
                        end
                    end
                    EPP_WNB: begin
                        if (!pinS.busy) begin
                            if (eppAddr_r) pin_r.hostSelN <= 1'b0;
                            else pin_r.autofdN <= 1'b0;
                            st_r <= EPP_WB;
                        end
                    end
                    EPP_WB: begin
                        if (pinS.busy) begin
                            pin_r.hostSelN <= 1'b1;
                            pin_r.autofdN <= 1'b1;
                            eppRd_r <= pinS.data;
                            st_r <= EPP_FIN;
                        end
                    end
                    EPP_FIN: begin
                        pin_r.strobeN <= 1'b1;
                        pin_r.dataOe <= 1'b0;
                        st_r <= EPP_IDLE;
                    end
                    default: st_r <= EPP_IDLE;
                endcase
            end
        end
    end

    // interrupt, DMA request and descriptor close status
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_r <= 1'b0;
            dmaReq_r <= 1'b0;
            close_r <= 2'b00;
        end else if (ce) begin
            irq_r <= ibr_r & ctrl_r[CB_IRQE];
            dmaReq_r <= ibr_r & ctrl_r[CB_DMA_REQUEST_ENABLE];
            close_r <= {cmd_r, to_r};
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign pinOut = pin_r;
    assign inboundIrq = irq_r;
    assign dmaReq = dmaReq_r;
    assign dmaCloseStat = close_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst || !ce);

    a_strobe_rev_high: assert property (revOn [*2] |-> pin_r.strobeN)
        else $error("strobe low in reverse mode");
    a_init_follows: assert property (##1 pin_r.initN == $past(ctrl_r[CB_INIT]))
        else $error("init pin not following control");
    a_afd_ack: assert property (accept |=> revAfdN_r ##1 pin_r.autofdN)
        else $error("autofd not raised after ack");
    a_ibr_four: assert property (cnt_r == 3'(RX_BYTES) |-> ibr_r)
        else $error("four bytes held without ready");
    a_dma_req: assert property (##1 dmaReq_r == $past(ibr_r && ctrl_r[CB_DMA_REQUEST_ENABLE]))
        else $error("dma request mismatch");
    a_cmd_close: assert property (accept && !pinS.busy |=> ibr_r && cmd_r)
        else $error("command byte did not close");
    a_flags_read: assert property (dataRead |=> !cmd_r && !to_r && !ibr_r)
        else $error("read left close flags set");
    a_timer_idle: assert property (cnt_r == 3'h0 |-> tmr_r == '0)
        else $error("timer ran with empty buffer");
    a_epp_stall: assert property (eppHit && laneOk && st_r != EPP_FIN |=> !pready_r)
        else $error("epp access ended early");
    a_epp_abort: assert property (eppHit && !laneOk |=> pready_r && pslverr_r)
        else $error("bad lane not refused");
    a_epp_hs_busy: assert property ($fell(pin_r.autofdN && pin_r.hostSelN) && eppMode
        |-> $past(!pinS.busy))
        else $error("handshake asserted while busy");
endmodule : iep_port_host

// ### iep_port_host_test.sv
module iep_port_host_test
    import iep_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, rst, ce, psel, penable, pwrite, pready, pslverr, rerr;
    logic inboundIrq, dmaReq, eppOn;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] pstrb;
    logic [1:0] dmaCloseStat;
    iep_pin_in_t pinIn;
    iep_pin_out_t pinOut;
    int bad_count = 0;
    int samples_checked = 0;
    int waitCyc;
    iep_port_host u_iep_port_host (.mclk(mclk), .rst(rst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut),
        .inboundIrq(inboundIrq), .dmaReq(dmaReq), .dmaCloseStat(dmaCloseStat));
    iep_periph_model u_iep_periph_model (.mclk(mclk), .eppOn(eppOn), .pinOut(pinOut),
        .pinIn(pinIn));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 400);
        rdat = prdata;
        rerr = pslverr;
        waitCyc = n;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 400) begin
            bad_count++;
            results();
        end
    endtask : apb
    task automatic t_reset();
        chk({pinOut.strobeN, pinOut.autofdN, pinOut.hostSelN, pinOut.initN}, 4'hF, "idle");
        apb(1'b0, PORT_CTRL_OFS, 32'h0, 4'h0);
        chk(rdat[15:0], CTRL_RST, "ctrl reset");
        chk(rdat[SB_FAULT -: 3], 3'b111, "pin levels");
        apb(1'b0, 12'h0FC, 32'h0, 4'h0);
        chk({rerr, rdat}, 33'h1_0000_0000, "unmapped");
    endtask : t_reset
    task automatic t_reverse();
        apb(1'b1, PORT_CTRL_OFS, 32'h0000_0139, 4'h3);
        repeat (4) @(posedge mclk);
        chk({pinOut.strobeN, pinOut.hostSelN, pinOut.initN}, 3'b110, "rev pins");
        apb(1'b0, PORT_CTRL_OFS, 32'h0, 4'h0);
        chk(rdat[SB_PE], 1'b0, "pe low");
        for (int i = 0; i < 4; i++) u_iep_periph_model.send(8'h11 * (i + 1), 1'b0);
        apb(1'b0, PORT_CTRL_OFS, 32'h0, 4'h0);
        chk({rdat[SB_IBR], rdat[SB_CNT +: 3]}, 4'b1100, "ready count");
        chk({dmaReq, inboundIrq}, 2'b11, "irq dma");
        apb(1'b0, CHAN_DATA_OFS, 32'h0, 4'h0);
        chk(rdat, 32'h4433_2211, "packed");
        chk(u_iep_periph_model.lost, 0, "ack handshake");
    endtask : t_reverse
    task automatic t_timer();
        int n;
        u_iep_periph_model.send(8'h7E, 1'b0);
        repeat (100) @(posedge mclk);
        chk(dmaCloseStat, 2'b00, "early close");
        n = 0;
        while (dmaCloseStat !== 2'b01 && n < 100) begin
            @(posedge mclk);
            n++;
        end
        chk(dmaCloseStat, 2'b01, "timeout close");
        apb(1'b0, PORT_CTRL_OFS, 32'h0, 4'h0);
        chk({rdat[SB_TO], rdat[SB_IBR], rdat[SB_CNT +: 3]}, 5'b11001, "timeout");
        apb(1'b0, CHAN_DATA_OFS, 32'h0, 4'h0);
        chk(rdat[7:0], 8'h7E, "partial");
        repeat (200) @(posedge mclk);
        chk({dmaCloseStat, inboundIrq}, 3'b000, "idle timer");
    endtask : t_timer
    task automatic t_close();
        u_iep_periph_model.send(8'hA1, 1'b0);
        u_iep_periph_model.send(8'hC2, 1'b1);
        apb(1'b0, PORT_CTRL_OFS, 32'h0, 4'h0);
        chk({rdat[SB_CMD], rdat[SB_IBR], rdat[SB_CNT +: 3]}, 5'b11010, "cmd close");
        chk(dmaCloseStat, 2'b10, "desc status");
        apb(1'b0, CHAN_DATA_OFS, 32'h0, 4'h0);
        chk(rdat[15:0], 16'hC2A1, "cmd byte");
        apb(1'b0, PORT_CTRL_OFS, 32'h0, 4'h0);
        chk(rdat[SB_CMD], 1'b0, "cmd cleared");
        apb(1'b1, PORT_CTRL_OFS, 32'h0000_013D, 4'h3);
        repeat (4) @(posedge mclk);
        apb(1'b0, PORT_CTRL_OFS, 32'h0, 4'h0);
        chk(rdat[SB_PE], 1'b1, "pe back");
    endtask : t_close
    task automatic t_epp();
        apb(1'b1, PORT_CTRL_OFS, 32'h0000_014E, 4'h3);
        eppOn <= 1'b1;
        apb(1'b1, CHAN_DATA_OFS, 32'h96, 4'h1);
        chk({rerr, u_iep_periph_model.lastWay, u_iep_periph_model.lastWr}, 13'h0696, "dw");
        chk(waitCyc > u_iep_periph_model.lag, 1'b1, "stall");
        apb(1'b1, CHAN_DATA_OFS, 32'h3C00, 4'h2);
        chk({rerr, u_iep_periph_model.lastWay, u_iep_periph_model.lastWr}, 13'h053C, "aw");
        apb(1'b0, CHAN_DATA_OFS, 32'h0, 4'h0);
        chk({rerr, u_iep_periph_model.lastWay, rdat[7:0]}, 13'h0A5A, "dr");
        u_iep_periph_model.lag = 0;
        apb(1'b0, CHAN_DATA_OFS + 12'h1, 32'h0, 4'h0);
        chk({rerr, u_iep_periph_model.lastWay, rdat[15:8]}, 13'h095A, "ar");
        apb(1'b1, CHAN_DATA_OFS, 32'hFFFF, 4'h3);
        chk(rerr, 1'b1, "halfword");
        apb(1'b0, CHAN_DATA_OFS + 12'h2, 32'h0, 4'h0);
        chk(rerr, 1'b1, "wrong lane");
    endtask : t_epp
    initial begin
        #4000000;
        bad_count++;
        results();
    end
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        eppOn = 1'b0;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_reverse();
        t_timer();
        t_close();
        t_epp();
        results();
    end
endmodule : iep_port_host_test
